// [hdl/dsg_pkg.sv]
// package: register map, field layout and unit indices for the clock gating block
package dsg_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [11:0] OFS_RUN_CLOCK_CONFIG = 12'h060;
  localparam logic [11:0] OFS_RUN_GATING = 12'h100;
  localparam logic [11:0] OFS_SLEEP_GATING = 12'h110;
  localparam logic [11:0] OFS_DEEP_SLEEP_GATING = 12'h120;

  // gating register field positions
  localparam int unsigned POS_WATCHDOG_GATE = 3;
  localparam int unsigned POS_HIBERNATION_GATE = 6;
  localparam int unsigned POS_RATE_LO = 8;
  localparam int unsigned POS_RATE_HI = 11;
  localparam int unsigned POS_CONVERTER_GATE = 16;
  localparam int unsigned POS_CONTROLLER_AREA_GATE = 24;

  // run clock configuration field position
  localparam int unsigned POS_AUTO_GATING_SELECT = 27;

  // writable bits; every other bit is reserved and reads zero
  localparam logic [31:0] GATING_WRITE_MASK = 32'h0101_0f48;
  localparam logic [31:0] RUN_CONFIG_WRITE_MASK = 32'h0800_0000;

  // reset values
  localparam logic [31:0] GATING_RESET = 32'h0000_0000;
  localparam logic [31:0] RUN_CONFIG_RESET = 32'h0000_0000;

  // converter rate codes
  localparam logic [3:0] RATE_125K = 4'h0;
  localparam logic [3:0] RATE_250K = 4'h1;
  localparam logic [3:0] RATE_500K = 4'h2;
  localparam logic [3:0] RATE_1M = 4'h3;
  localparam logic [3:0] RATE_MAX = RATE_1M;

  // gated units, index into the enable and fault vectors
  localparam int unsigned NUM_UNITS = 4;
  localparam int unsigned UNIT_WATCHDOG = 0;
  localparam int unsigned UNIT_HIBERNATION = 1;
  localparam int unsigned UNIT_CONVERTER = 2;
  localparam int unsigned UNIT_CONTROLLER_AREA = 3;

  // units that answer an unclocked access with a bus fault
  localparam logic [3:0] UNIT_FAULTS = 4'b1101;

  // power modes seen by the gating selector
  typedef enum logic [1:0] {
    DSG_MODE_RUN,
    DSG_MODE_SLEEP,
    DSG_MODE_DEEP
  } dsg_mode_e;

endpackage

// [hdl/dsg_gate_channel.sv]
// one gated unit: registered clock enable and bus fault on unclocked access
`timescale 1ns/1ps
module dsg_gate_channel #(
  parameter bit FAULT_ON_GATED = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // selected gate and unit access
  input wire logic gate_sel,
  input wire logic unit_access,
  // results
  output logic clk_en,
  output logic bus_fault
);

  // enable is a flop so the downstream clock gate sees a glitch-free level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_en <= 1'b0;
    end else begin
      clk_en <= gate_sel;
    end
  end

  // fault judged against the enable the unit actually has right now
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_fault <= 1'b0;
    end else begin
      bus_fault <= FAULT_ON_GATED & unit_access & ~clk_en;
    end
  end

endmodule // dsg_gate_channel

// [hdl/dsg_clock_gating.sv]
// top: run, sleep and deep-sleep clock gating registers with mode selection
// Function
// - set bit clocks its unit, clear stops it
// - access to unclocked unit raises bus fault
// - all gating bits cleared at reset
// - run, sleep, deep-sleep registers applied per mode
// - sleep registers apply only with auto select
// - deep-sleep register decodes at offset 0x120
// - bit 6 gates hibernation, no fault
// - bit 3 gates watchdog, faults when gated
// - rate field 11:8 picks converter sample rate
// - rate never exceeds converter maximum
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module dsg_clock_gating
  import dsg_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // power mode from the core, same clock
  input wire logic SLEEP,
  input wire logic DEEP_SLEEP,
  // unit bus accesses, one bit per unit
  input wire logic [NUM_UNITS-1:0] UNIT_ACCESS,
  // clock enables, bus faults and converter rate
  output logic [NUM_UNITS-1:0] UNIT_CLK_EN,
  output logic [NUM_UNITS-1:0] BUS_FAULT,
  output logic [3:0] CONVERTER_RATE
);

  logic [31:0] run_clock_config;
  logic [31:0] run_gating_register;
  logic [31:0] sleep_gating_register;
  logic [31:0] deep_sleep_gating_register;
  logic [31:0] next_gating;
  logic [31:0] sel_gating;
  logic [NUM_UNITS-1:0] sel_gate;
  logic [31:0] next_rdata;
  logic auto_gating_select;
  dsg_mode_e mode;

  assign auto_gating_select = run_clock_config[POS_AUTO_GATING_SELECT];

  // write value: reserved bits forced low, rate clamped to the converter limit
  always_comb begin
    next_gating = WDATA & GATING_WRITE_MASK;
    if (WDATA[POS_RATE_HI:POS_RATE_LO] > RATE_MAX) begin
      next_gating[POS_RATE_HI:POS_RATE_LO] = RATE_MAX;
    end
  end

  // run clock configuration, only the auto select bit is kept
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      run_clock_config <= RUN_CONFIG_RESET;
    end else if (WR && ADDR == OFS_RUN_CLOCK_CONFIG) begin
      run_clock_config <= WDATA & RUN_CONFIG_WRITE_MASK;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      run_gating_register <= GATING_RESET;
    end else if (WR && ADDR == OFS_RUN_GATING) begin
      run_gating_register <= next_gating;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sleep_gating_register <= GATING_RESET;
    end else if (WR && ADDR == OFS_SLEEP_GATING) begin
      sleep_gating_register <= next_gating;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      deep_sleep_gating_register <= GATING_RESET;
    end else if (WR && ADDR == OFS_DEEP_SLEEP_GATING) begin
      deep_sleep_gating_register <= next_gating;
    end
  end

  // read data stands one cycle after the strobe and is zero otherwise
  always_comb begin
    next_rdata = '0;
    if (RD) begin
      unique case (ADDR)
        OFS_RUN_CLOCK_CONFIG: next_rdata = run_clock_config;
        OFS_RUN_GATING: next_rdata = run_gating_register;
        OFS_SLEEP_GATING: next_rdata = sleep_gating_register;
        OFS_DEEP_SLEEP_GATING: next_rdata = deep_sleep_gating_register;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= '0;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // deep sleep wins over sleep; without auto select the core counts as running
  always_comb begin
    if (!auto_gating_select) begin
      mode = DSG_MODE_RUN;
    end else if (DEEP_SLEEP) begin
      mode = DSG_MODE_DEEP;
    end else if (SLEEP) begin
      mode = DSG_MODE_SLEEP;
    end else begin
      mode = DSG_MODE_RUN;
    end
  end

  always_comb begin
    unique case (mode)
      DSG_MODE_RUN: sel_gating = run_gating_register;
      DSG_MODE_SLEEP: sel_gating = sleep_gating_register;
      DSG_MODE_DEEP: sel_gating = deep_sleep_gating_register;
      // fourth code of the two-bit mode is illegal; fall back to run gating
      default: sel_gating = run_gating_register;
    endcase
  end

  always_comb begin
    sel_gate[UNIT_WATCHDOG] = sel_gating[POS_WATCHDOG_GATE];
    sel_gate[UNIT_HIBERNATION] = sel_gating[POS_HIBERNATION_GATE];
    sel_gate[UNIT_CONVERTER] = sel_gating[POS_CONVERTER_GATE];
    sel_gate[UNIT_CONTROLLER_AREA] = sel_gating[POS_CONTROLLER_AREA_GATE];
  end

  // rate follows the active register; stored values are already clamped
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CONVERTER_RATE <= RATE_125K;
    end else begin
      CONVERTER_RATE <= sel_gating[POS_RATE_HI:POS_RATE_LO];
    end
  end

  // one channel per unit; hibernation keeps its own bus, so it never faults
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    dsg_gate_channel #(
      .FAULT_ON_GATED(UNIT_FAULTS[u])
    ) u_channel (
      .ref_clk(REF_CLK),
      .rstn(RSTN),
      .gate_sel(sel_gate[u]),
      .unit_access(UNIT_ACCESS[u]),
      .clk_en(UNIT_CLK_EN[u]),
      .bus_fault(BUS_FAULT[u])
    );
  end

  // checks
  a_gate_follow: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 UNIT_CLK_EN == $past(sel_gate))
    else $error("unit clock enable does not follow selected gate");

  a_fault_cause: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    (UNIT_ACCESS & ~UNIT_CLK_EN & UNIT_FAULTS) != '0
      |=> (BUS_FAULT & $past(UNIT_ACCESS & ~UNIT_CLK_EN & UNIT_FAULTS)) != '0)
    else $error("access to unclocked unit gave no bus fault");

  a_fault_no_false: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    BUS_FAULT != '0 |-> (BUS_FAULT & ~$past(UNIT_ACCESS & ~UNIT_CLK_EN)) == '0)
    else $error("bus fault without unclocked access");

  a_reset_clear: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    $rose(RSTN) |-> deep_sleep_gating_register == GATING_RESET
      && sleep_gating_register == GATING_RESET && run_gating_register == GATING_RESET
      && UNIT_CLK_EN == '0)
    else $error("gating bits not clear after reset");

  a_deep_apply: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    auto_gating_select && DEEP_SLEEP
      |=> UNIT_CLK_EN[UNIT_WATCHDOG] == $past(deep_sleep_gating_register[POS_WATCHDOG_GATE]))
    else $error("deep sleep register not applied in deep sleep");

  a_sleep_apply: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    auto_gating_select && SLEEP && !DEEP_SLEEP
      |=> CONVERTER_RATE == $past(sleep_gating_register[POS_RATE_HI:POS_RATE_LO]))
    else $error("sleep register not applied in sleep");

  a_auto_off: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !auto_gating_select
      |=> UNIT_CLK_EN[UNIT_CONVERTER] == $past(run_gating_register[POS_CONVERTER_GATE]))
    else $error("run register not applied without auto select");

  a_deep_decode: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    WR && ADDR == OFS_DEEP_SLEEP_GATING && WDATA[POS_RATE_HI:POS_RATE_LO] <= RATE_MAX
      |=> deep_sleep_gating_register == ($past(WDATA) & GATING_WRITE_MASK))
    else $error("deep sleep register write at its offset lost");

  a_hib_quiet: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !BUS_FAULT[UNIT_HIBERNATION])
    else $error("hibernation unit raised a bus fault");

  a_wdt_fault: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    UNIT_ACCESS[UNIT_WATCHDOG] && !UNIT_CLK_EN[UNIT_WATCHDOG]
      |=> BUS_FAULT[UNIT_WATCHDOG])
    else $error("watchdog access while gated did not fault");

  a_rate_select: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 CONVERTER_RATE == $past(sel_gating[POS_RATE_HI:POS_RATE_LO]))
    else $error("converter rate does not follow selected field");

  a_rate_limit: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CONVERTER_RATE <= RATE_MAX && run_gating_register[POS_RATE_HI:POS_RATE_LO] <= RATE_MAX
      && sleep_gating_register[POS_RATE_HI:POS_RATE_LO] <= RATE_MAX
      && deep_sleep_gating_register[POS_RATE_HI:POS_RATE_LO] <= RATE_MAX)
    else $error("converter rate above maximum");

  a_can_fault: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    UNIT_ACCESS[UNIT_CONTROLLER_AREA] && !UNIT_CLK_EN[UNIT_CONTROLLER_AREA]
      |=> BUS_FAULT[UNIT_CONTROLLER_AREA])
    else $error("controller area access while gated did not fault");

  a_read_once: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    !RD |=> RDATA == '0)
    else $error("read data present without a read strobe");

  a_conv_fault: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    UNIT_ACCESS[UNIT_CONVERTER] && !UNIT_CLK_EN[UNIT_CONVERTER]
      |=> BUS_FAULT[UNIT_CONVERTER])
    else $error("converter access while gated did not fault");

  a_hib_follow: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 UNIT_CLK_EN[UNIT_HIBERNATION] == $past(sel_gating[POS_HIBERNATION_GATE]))
    else $error("hibernation enable does not follow bit 6");

  a_wdt_follow: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 UNIT_CLK_EN[UNIT_WATCHDOG] == $past(sel_gating[POS_WATCHDOG_GATE]))
    else $error("watchdog enable does not follow bit 3");

  a_can_follow: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 UNIT_CLK_EN[UNIT_CONTROLLER_AREA] == $past(sel_gating[POS_CONTROLLER_AREA_GATE]))
    else $error("controller area enable does not follow bit 24");

  a_conv_follow: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ##1 UNIT_CLK_EN[UNIT_CONVERTER] == $past(sel_gating[POS_CONVERTER_GATE]))
    else $error("converter enable does not follow bit 16");

  a_run_decode: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    WR && ADDR == OFS_RUN_GATING && WDATA[POS_RATE_HI:POS_RATE_LO] <= RATE_MAX
      |=> run_gating_register == ($past(WDATA) & GATING_WRITE_MASK))
    else $error("run gating register write at its offset lost");

  a_sleep_decode: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    WR && ADDR == OFS_SLEEP_GATING && WDATA[POS_RATE_HI:POS_RATE_LO] <= RATE_MAX
      |=> sleep_gating_register == ($past(WDATA) & GATING_WRITE_MASK))
    else $error("sleep gating register write at its offset lost");

  a_reserved_zero: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    ((run_gating_register | sleep_gating_register | deep_sleep_gating_register)
      & ~GATING_WRITE_MASK) == '0 && (run_clock_config & ~RUN_CONFIG_WRITE_MASK) == '0)
    else $error("reserved register bit is set");

  a_rate_clamp: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    WR && ADDR == OFS_DEEP_SLEEP_GATING && WDATA[POS_RATE_HI:POS_RATE_LO] > RATE_MAX
      |=> deep_sleep_gating_register[POS_RATE_HI:POS_RATE_LO] == RATE_MAX)
    else $error("rate write above maximum not clamped");

  a_read_data: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    RD && ADDR == OFS_DEEP_SLEEP_GATING
      |=> RDATA == $past(deep_sleep_gating_register))
    else $error("deep sleep register read at its offset wrong");

  a_unmapped_read: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    RD && ADDR != OFS_RUN_CLOCK_CONFIG && ADDR != OFS_RUN_GATING
      && ADDR != OFS_SLEEP_GATING && ADDR != OFS_DEEP_SLEEP_GATING
      |=> RDATA == '0)
    else $error("unmapped read returned data");

  a_deep_priority: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    auto_gating_select && DEEP_SLEEP && SLEEP
      |=> CONVERTER_RATE == $past(deep_sleep_gating_register[POS_RATE_HI:POS_RATE_LO]))
    else $error("deep sleep did not win over sleep");

  a_run_apply: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    auto_gating_select && !SLEEP && !DEEP_SLEEP
      |=> UNIT_CLK_EN[UNIT_HIBERNATION] == $past(run_gating_register[POS_HIBERNATION_GATE]))
    else $error("run register not applied while running");

  c_wdt_fault: cover property (
    @(posedge REF_CLK) disable iff (!RSTN) BUS_FAULT[UNIT_WATCHDOG]);

  c_deep_gate: cover property (
    @(posedge REF_CLK) disable iff (!RSTN)
    mode == DSG_MODE_DEEP ##1 UNIT_CLK_EN[UNIT_CONVERTER]);

  c_rate_clamp: cover property (
    @(posedge REF_CLK) disable iff (!RSTN)
    WR && WDATA[POS_RATE_HI:POS_RATE_LO] > RATE_MAX);

  c_sleep_mode: cover property (
    @(posedge REF_CLK) disable iff (!RSTN) mode == DSG_MODE_SLEEP);

  c_conv_fault: cover property (
    @(posedge REF_CLK) disable iff (!RSTN) BUS_FAULT[UNIT_CONVERTER]);

endmodule // dsg_clock_gating

// [test/tb_dsg_clock_gating.sv]
// self-checking bench for the deep-sleep clock gating block
`timescale 1ns/1ps
module tb_dsg_clock_gating;
  import dsg_pkg::*;
  logic ref_clk;
  logic rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic sleep;
  logic deep_sleep;
  logic [NUM_UNITS-1:0] unit_access;
  logic [NUM_UNITS-1:0] unit_clk_en;
  logic [NUM_UNITS-1:0] bus_fault;
  logic [3:0] converter_rate;
  int failures;
  int cmp_count;

  dsg_clock_gating dut (
    .REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SLEEP(sleep), .DEEP_SLEEP(deep_sleep), .UNIT_ACCESS(unit_access),
    .UNIT_CLK_EN(unit_clk_en), .BUS_FAULT(bus_fault), .CONVERTER_RATE(converter_rate)
  );

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // enables follow a register change one edge after the write edge
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    check(32'(unit_clk_en), 32'h0);
    check(32'(converter_rate), 32'h0);
    check(32'(bus_fault), 32'h0);
    rd_reg(OFS_DEEP_SLEEP_GATING, d);
    check(d, GATING_RESET);
    rd_reg(OFS_SLEEP_GATING, d);
    check(d, 32'h0000_0000);
    rd_reg(OFS_RUN_GATING, d);
    check(d, 32'h0000_0000);
  endtask

  task automatic t_map();
    logic [31:0] d;
    wr_reg(12'h120, 32'hffff_ffff);
    rd_reg(12'h120, d);
    check(d, 32'h0101_0348);
    wr_reg(12'h124, 32'hffff_ffff);
    rd_reg(12'h124, d);
    check(d, 32'h0000_0000);
    @(posedge ref_clk);
    #1;
    check(rdata, 32'h0000_0000);
  endtask

  // codes above the maximum must come back clamped to the top rate
  task automatic t_rate();
    logic [31:0] d;
    logic [3:0] codes [5];
    logic [3:0] exp [5];
    codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
    exp = '{RATE_125K, RATE_250K, RATE_500K, RATE_1M, RATE_1M};
    for (int i = 0; i < 5; i++) begin
      wr_reg(12'h100, {20'h0, codes[i], 8'h0});
      settle();
      check(32'(converter_rate), 32'(exp[i]));
      rd_reg(12'h100, d);
      check(d, {20'h0, exp[i], 8'h0});
    end
  endtask

  task automatic t_mode();
    logic [31:0] d;
    wr_reg(12'h100, 32'h0000_0008);
    wr_reg(12'h110, 32'h0001_0000);
    wr_reg(12'h120, 32'h0101_0100);
    sleep <= 1'b1;
    settle();
    check(32'(unit_clk_en), 32'h1);
    wr_reg(12'h060, 32'hffff_ffff);
    rd_reg(12'h060, d);
    check(d, 32'h0800_0000);
    settle();
    check(32'(unit_clk_en), 32'h4);
    @(posedge ref_clk);
    deep_sleep <= 1'b1;
    settle();
    check(32'(unit_clk_en), 32'hc);
    check(32'(converter_rate), 32'h1);
    @(posedge ref_clk);
    sleep <= 1'b0;
    settle();
    check(32'(unit_clk_en), 32'hc);
    @(posedge ref_clk);
    deep_sleep <= 1'b0;
    settle();
    check(32'(unit_clk_en), 32'h1);
    check(32'(converter_rate), 32'h0);
  endtask

  // reset again in mid-run; registers and enables fall back to zero
  task automatic t_rereset();
    logic [31:0] d;
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    check(32'(unit_clk_en), 32'h0);
    check(32'(converter_rate), 32'h0);
    rd_reg(12'h060, d);
    check(d, 32'h0000_0000);
    rd_reg(12'h100, d);
    check(d, 32'h0000_0000);
  endtask

  task automatic access(input logic [3:0] v, input logic [3:0] exp);
    @(posedge ref_clk);
    unit_access <= v;
    @(posedge ref_clk);
    unit_access <= 4'h0;
    #1;
    check(32'(bus_fault), 32'(exp));
    @(posedge ref_clk);
    #1;
    check(32'(bus_fault), 32'h0);
  endtask

  // hibernation never faults, gated or not
  task automatic t_fault();
    wr_reg(12'h100, 32'h0000_0000);
    settle();
    access(4'hf, 4'hd);
    wr_reg(12'h100, 32'h0101_0048);
    settle();
    check(32'(unit_clk_en), 32'hf);
    access(4'hf, 4'h0);
    wr_reg(12'h100, 32'h0000_0040);
    settle();
    access(4'h1, 4'h1);
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    sleep = 1'b0;
    deep_sleep = 1'b0;
    unit_access = '0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_map();
    t_rate();
    t_mode();
    t_fault();
    t_rereset();
    complete_run();
  end

  // the sequence needs about a hundred cycles; this leaves ample margin
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule // tb_dsg_clock_gating
